/* File: core/tcbsr_pkg.sv */
package tcbsr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_OUT_B = 8'h07;
  localparam logic [7:0] ADDR_OUT_C = 8'h08;
  localparam logic [7:0] ADDR_RD_EDGE = 8'h09;
  localparam logic [7:0] ADDR_SID2 = 8'h18;
  localparam logic [7:0] ADDR_SID3 = 8'h19;
  localparam logic [7:0] ADDR_STATUS = 8'h1A;
  localparam logic [7:0] ADDR_GSID = 8'h1B;
  localparam logic [7:0] ADDR_PM_TRIG = 8'h1C;
  localparam logic [7:0] ADDR_TOP = 8'h1F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EDGE_BIT = 0;
  localparam int SWR_BIT = 7;
  localparam int FLAG_CMD_PAR = 6;
  localparam int FLAG_LEN = 5;
  localparam int FLAG_ADDR_PAR = 4;
  localparam int FLAG_DATA_PAR = 3;
  localparam int FLAG_BAD_RD = 2;
  localparam int FLAG_BAD_WR = 1;
  localparam int FLAG_BC_RD = 0;
  // Power mode bits and trigger bits only
  localparam logic [7:0] GROUP_WR_MASK = 8'hC7;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic RST_EDGE = 1'b0;
  localparam logic [3:0] RST_SID = 4'h7;
  localparam logic [3:0] RST_GSID = 4'h0;
  localparam logic [6:0] RST_FLAGS = 7'h00;

  // ****************************************
  // Protocol codes and link edge counts
  // ****************************************
  localparam logic [3:0] BROADCAST_SA = 4'h0;
  localparam logic [1:0] PM_STARTUP = 2'h1;
  localparam logic [2:0] OP_REG_WR = 3'h2;
  localparam logic [2:0] OP_REG_RD = 3'h3;
  localparam logic [3:0] OP_EXT_WR = 4'h0;
  localparam logic [3:0] OP_EXT_RD = 4'h2;
  localparam logic [3:0] CMD_LAST = 4'hC;
  localparam logic [3:0] FRAME_LAST = 4'h8;
  localparam logic [4:0] RD_OFF_RISE = 5'h03;
  localparam logic [4:0] RD_OFF_FALL = 5'h02;
  localparam logic [3:0] RD_PARK = 4'h9;
  localparam logic [4:0] RD_END = 5'h16;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CMD = 6'h02,
    ST_ADDR = 6'h04,
    ST_WDATA = 6'h08,
    ST_READ = 6'h10,
    ST_WAIT = 6'h20
  } tcbsr_state_t;

  typedef struct packed {
    logic glide_start;
    logic turbo_start;
    logic glide;
    logic [6:0] target;
    logic [4:0] step_delay;
  } tcbsr_chan_t;

  typedef struct packed {
    logic valid;
    logic group;
    logic bcast;
    logic [4:0] addr;
    logic [7:0] data;
  } tcbsr_ext_wr_t;

  typedef struct packed {
    logic [1:0][7:0] out_val;
    logic rd_edge;
  } tcbsr_otp_t;

endpackage

/* File: core/tcbsr_regs.sv */
// Functional notes
// - Output B/C hold 7-bit target; bit 7 set with nonzero timer starts glide.
// - Glide bit clear with nonzero timer applies target by turbo transition.
// - Output reads return active post-trigger target, not shadow or analog drive.
// - Read-timing bit 0 set launches read data on falling clock edge, else rising.
// - Second and third identifiers accept new value from broadcast write, address zero.
// - Each identifier also changes by individual write addressed with its current value.
// - Identifier writes need upper nibble equal hardwired maker bits, else ignored.
// - Identifiers and group identifier return to reset after shutdown power mode.
// - Status bit 7 write one soft-resets registers except ids and trigger register.
// - Soft reset acts in the last cycle of the setting frame.
// - Soft reset loads programmable-memory values for duplicated registers.
// - Status bits 6..0 hardware set; cleared by read, soft reset, startup, reset.
// - Command frame parity error sets bit 6, whole sequence ignored.
// - Early sequence start sets bit 5; complete correct frames kept.
// - Multi-byte read answered with exactly one data byte.
// - Address frame parity error sets bit 4, whole sequence ignored.
// - Data frame parity error sets bit 3, drops only that byte.
// - Read of missing register sets bit 2, data line left idle.
// - Write to missing register sets bit 1, data discarded, next frame normal.
// - Read with broadcast address sets bit 0, sequence ignored.
// - Group identifier written by any unique identifier, kept over soft reset.
// - Group-addressed frames write only power-mode and trigger bits.
// - Trigger copies shadow to active unless mask makes update immediate.
// - Glide step delay equals channel step timer, ignoring turbo doubling.
module tcbsr_regs #(
  // Hardwired upper identifier nibble; value arbitrary
  parameter logic [3:0] MAKER_NIBBLE = 4'hA
) (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sclk_in,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe_out,
  input wire logic [3:0] first_sid_in,
  input wire logic [1:0] power_state_in,
  input wire logic shutdown_in,
  input wire logic [1:0] trig_mask_in,
  input wire logic [1:0] trig_fire_in,
  input wire logic [1:0][4:0] step_timer_in,
  input wire logic otp_valid_in,
  input tcbsr_pkg::tcbsr_otp_t otp_in,
  output tcbsr_pkg::tcbsr_chan_t [1:0] chan_out,
  output tcbsr_pkg::tcbsr_ext_wr_t ext_wr_out,
  output logic [6:0] flags_out
);

  // ****************************************
  // Address decode helpers
  // ****************************************
  function automatic logic tcbsr_is_ours(input logic [7:0] a);
    tcbsr_is_ours = (a == tcbsr_pkg::ADDR_OUT_B) || (a == tcbsr_pkg::ADDR_OUT_C)
      || (a == tcbsr_pkg::ADDR_RD_EDGE) || (a == tcbsr_pkg::ADDR_SID2)
      || (a == tcbsr_pkg::ADDR_SID3) || (a == tcbsr_pkg::ADDR_STATUS)
      || (a == tcbsr_pkg::ADDR_GSID);
  endfunction

  function automatic logic tcbsr_is_present(input logic [7:0] a);
    tcbsr_is_present = (a <= tcbsr_pkg::ADDR_RD_EDGE)
      || ((a >= tcbsr_pkg::ADDR_SID2) && (a <= tcbsr_pkg::ADDR_TOP));
  endfunction

  tcbsr_pkg::tcbsr_state_t state;
  tcbsr_pkg::tcbsr_state_t next_state;
  logic [2:0] sclk_sync;
  logic [2:0] sdata_sync;
  logic sclk_f;
  logic sdata_f;
  logic rise;
  logic fall;
  logic ssc;
  logic [12:0] sh;
  logic [12:0] sh_next;
  logic [3:0] nbit;
  logic [7:0] addr;
  logic [4:0] left;
  logic is_rd;
  logic cls_bc;
  logic cls_grp;
  logic [3:0] cls_sa;
  logic [4:0] rd_cnt;
  logic [8:0] rd_word;
  logic [7:0] shadow [2];
  logic rd_edge;
  logic [3:0] sid2;
  logic [3:0] sid3;
  logic [3:0] gsid;
  logic startup;
  logic [7:0] cmd_op;
  logic [3:0] cmd_sa;
  logic sa_bc;
  logic sa_ind;
  logic sa_grp;
  logic par_ok;
  logic frame_end;
  logic [7:0] look_addr;
  logic [7:0] rd_mux;
  logic rd_go;
  logic wr_go;
  logic [7:0] wr_data;
  logic [1:0] chan_wr;
  logic swr_go;
  logic stat_clr;
  logic [6:0] flag_set;
  logic [4:0] rd_cnt_n;
  logic [4:0] rd_off;
  logic [4:0] rd_step;
  logic launch;
  logic rd_end;
  logic ext_hit;

  assign startup = (power_state_in == tcbsr_pkg::PM_STARTUP);

  // ****************************************
  // Link pin synchronisers
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      sclk_sync <= 3'h0;
      sdata_sync <= 3'h0;
      sclk_f <= 1'b0;
      sdata_f <= 1'b0;
    end
    else
    begin
      sclk_sync <= {sclk_sync[1:0], sclk_in};
      sdata_sync <= {sdata_sync[1:0], sdata_in};
      if (sclk_sync[1] == sclk_sync[2])
        sclk_f <= sclk_sync[2];
      if (sdata_sync[1] == sdata_sync[2])
        sdata_f <= sdata_sync[2];
    end
  end

  assign rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_f;
  assign fall = (sclk_sync[1] == sclk_sync[2]) && !sclk_sync[2] && sclk_f;
  // Own read data would look like a start; ignore it while answering
  assign ssc = (sdata_sync[1] == sdata_sync[2]) && !sdata_sync[2] && sdata_f && !sclk_f
    && (state != tcbsr_pkg::ST_READ);

  // ****************************************
  // Frame decode
  // ****************************************
  always_comb
  begin
    sh_next = {sh[11:0], sdata_f};
    cmd_op = sh_next[8:1];
    cmd_sa = sh_next[12:9];
    sa_bc = (cmd_sa == tcbsr_pkg::BROADCAST_SA);
    sa_ind = (cmd_sa == first_sid_in) || (cmd_sa == sid2) || (cmd_sa == sid3);
    sa_grp = (cmd_sa == gsid) && !sa_bc && !sa_ind;
    // Odd parity over data and parity bit
    par_ok = ^sh_next;
    wr_data = sh_next[8:1];
    look_addr = (state == tcbsr_pkg::ST_CMD) ? {3'h0, cmd_op[4:0]} : sh_next[8:1];
    frame_end = 1'b0;
    rd_go = 1'b0;
    wr_go = 1'b0;
    flag_set = tcbsr_pkg::RST_FLAGS;
    next_state = state;
    case (state)
      tcbsr_pkg::ST_CMD:
      begin
        frame_end = fall && (nbit == tcbsr_pkg::CMD_LAST);
        if (frame_end)
        begin
          next_state = tcbsr_pkg::ST_WAIT;
          if (!par_ok)
            flag_set[tcbsr_pkg::FLAG_CMD_PAR] = 1'b1;
          else if (cmd_op[7:5] == tcbsr_pkg::OP_REG_RD || cmd_op[7:4] == tcbsr_pkg::OP_EXT_RD)
          begin
            if (sa_bc)
              flag_set[tcbsr_pkg::FLAG_BC_RD] = 1'b1;
            else if (sa_ind && cmd_op[7:4] == tcbsr_pkg::OP_EXT_RD)
              next_state = tcbsr_pkg::ST_ADDR;
            else if (sa_ind && tcbsr_is_ours(look_addr))
              rd_go = 1'b1;
          end
          else if (sa_bc || sa_ind || sa_grp)
          begin
            if (cmd_op[7:5] == tcbsr_pkg::OP_REG_WR)
              next_state = tcbsr_pkg::ST_WDATA;
            else if (cmd_op[7:4] == tcbsr_pkg::OP_EXT_WR)
              next_state = tcbsr_pkg::ST_ADDR;
          end
        end
      end
      tcbsr_pkg::ST_ADDR:
      begin
        frame_end = fall && (nbit == tcbsr_pkg::FRAME_LAST);
        if (frame_end)
        begin
          next_state = tcbsr_pkg::ST_WAIT;
          if (!par_ok)
            flag_set[tcbsr_pkg::FLAG_ADDR_PAR] = 1'b1;
          else if (!is_rd)
            next_state = tcbsr_pkg::ST_WDATA;
          else if (tcbsr_is_ours(look_addr))
            rd_go = 1'b1;
          else if (!tcbsr_is_present(look_addr))
            flag_set[tcbsr_pkg::FLAG_BAD_RD] = 1'b1;
        end
      end
      tcbsr_pkg::ST_WDATA:
      begin
        frame_end = fall && (nbit == tcbsr_pkg::FRAME_LAST);
        if (frame_end)
        begin
          if (left == 5'h01)
            next_state = tcbsr_pkg::ST_WAIT;
          if (!par_ok)
            flag_set[tcbsr_pkg::FLAG_DATA_PAR] = 1'b1;
          else
            wr_go = 1'b1;
          if (par_ok && !cls_grp && !tcbsr_is_present(addr))
            flag_set[tcbsr_pkg::FLAG_BAD_WR] = 1'b1;
        end
      end
      tcbsr_pkg::ST_READ:
      begin
        if (rd_end)
          next_state = tcbsr_pkg::ST_WAIT;
      end
      default:
      begin
        next_state = state;
      end
    endcase
    // Accepted read moves on to the answer phase
    if (rd_go)
      next_state = tcbsr_pkg::ST_READ;
    // read of a missing register answered by silence
    if (rd_go == 1'b0 && frame_end && par_ok && state == tcbsr_pkg::ST_CMD && sa_ind
      && cmd_op[7:5] == tcbsr_pkg::OP_REG_RD && !tcbsr_is_present(look_addr))
      flag_set[tcbsr_pkg::FLAG_BAD_RD] = 1'b1;
    // sequence start before the command, address or data frames completed
    if (ssc && (state == tcbsr_pkg::ST_ADDR || state == tcbsr_pkg::ST_WDATA
      || (state == tcbsr_pkg::ST_CMD && nbit != 4'h0)))
      flag_set[tcbsr_pkg::FLAG_LEN] = 1'b1;
  end

  // ****************************************
  // Register read mux and write strobes
  // ****************************************
  always_comb
  begin
    case (look_addr)
      tcbsr_pkg::ADDR_OUT_B: rd_mux = {chan_out[0].glide, chan_out[0].target};
      tcbsr_pkg::ADDR_OUT_C: rd_mux = {chan_out[1].glide, chan_out[1].target};
      tcbsr_pkg::ADDR_RD_EDGE: rd_mux = {7'h00, rd_edge};
      tcbsr_pkg::ADDR_SID2: rd_mux = {MAKER_NIBBLE, sid2};
      tcbsr_pkg::ADDR_SID3: rd_mux = {MAKER_NIBBLE, sid3};
      tcbsr_pkg::ADDR_STATUS: rd_mux = {1'b0, flags_out};
      tcbsr_pkg::ADDR_GSID: rd_mux = {4'h0, gsid};
      default: rd_mux = 8'h00;
    endcase
  end

  // group frames reach only the trigger register
  assign chan_wr[0] = wr_go && !cls_grp && (addr == tcbsr_pkg::ADDR_OUT_B);
  assign chan_wr[1] = wr_go && !cls_grp && (addr == tcbsr_pkg::ADDR_OUT_C);
  assign swr_go = wr_go && !cls_grp && (addr == tcbsr_pkg::ADDR_STATUS) && wr_data[tcbsr_pkg::SWR_BIT];
  assign ext_hit = tcbsr_is_present(addr) && !tcbsr_is_ours(addr)
    && (!cls_grp || addr == tcbsr_pkg::ADDR_PM_TRIG);

  // ****************************************
  // Read launch timing
  // ****************************************
  assign rd_cnt_n = rd_cnt + 5'h01;
  assign rd_off = rd_edge ? tcbsr_pkg::RD_OFF_FALL : tcbsr_pkg::RD_OFF_RISE;
  assign rd_step = rd_cnt_n - rd_off;
  assign launch = (state == tcbsr_pkg::ST_READ) && (rd_edge ? fall : rise)
    && (rd_cnt_n >= rd_off) && !rd_step[0] && (rd_step[4:1] <= tcbsr_pkg::RD_PARK);
  assign rd_end = (state == tcbsr_pkg::ST_READ) && fall && (rd_cnt_n == tcbsr_pkg::RD_END);
  // clear once the read frame is over
  assign stat_clr = rd_end && (addr == tcbsr_pkg::ADDR_STATUS);

  // ****************************************
  // Frame engine
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
    begin
      state <= tcbsr_pkg::ST_IDLE;
      sh <= 13'h0000;
      nbit <= 4'h0;
      addr <= 8'h00;
      left <= 5'h00;
      is_rd <= 1'b0;
      cls_bc <= 1'b0;
      cls_grp <= 1'b0;
      cls_sa <= 4'h0;
      rd_cnt <= 5'h00;
      rd_word <= 9'h000;
      sdata_out <= 1'b0;
      sdata_oe_out <= 1'b0;
    end
    else if (ssc)
    begin
      state <= tcbsr_pkg::ST_CMD;
      sh <= 13'h0000;
      nbit <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (fall && state != tcbsr_pkg::ST_READ)
      begin
        sh <= frame_end ? 13'h0000 : sh_next;
        nbit <= frame_end ? 4'h0 : nbit + 4'h1;
      end
      if (frame_end && state == tcbsr_pkg::ST_CMD)
      begin
        cls_sa <= cmd_sa;
        cls_bc <= sa_bc;
        cls_grp <= sa_grp;
        addr <= look_addr;
        is_rd <= (cmd_op[7:4] == tcbsr_pkg::OP_EXT_RD);
        left <= (cmd_op[7:5] == tcbsr_pkg::OP_REG_WR) ? 5'h01 : {1'b0, cmd_op[3:0]} + 5'h01;
      end
      if (frame_end && state == tcbsr_pkg::ST_ADDR)
        addr <= look_addr;
      if (frame_end && state == tcbsr_pkg::ST_WDATA)
      begin
        addr <= addr + 8'h01;
        left <= left - 5'h01;
      end
      // one data byte whatever the requested count
      if (rd_go)
      begin
        rd_word <= {rd_mux, ~^rd_mux};
        rd_cnt <= 5'h00;
      end
      else if (state == tcbsr_pkg::ST_READ && (rise || fall))
        rd_cnt <= rd_cnt_n;
      if (launch)
      begin
        sdata_oe_out <= 1'b1;
        sdata_out <= (rd_step[4:1] == tcbsr_pkg::RD_PARK) ? 1'b0
          : rd_word[tcbsr_pkg::FRAME_LAST - rd_step[4:1]];
      end
      if (rd_end)
      begin
        sdata_oe_out <= 1'b0;
        sdata_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // Identifier registers
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    // shutdown loses identifiers; soft reset does not
    if (!resetn_in || startup || shutdown_in)
    begin
      sid2 <= tcbsr_pkg::RST_SID;
      sid3 <= tcbsr_pkg::RST_SID;
      gsid <= tcbsr_pkg::RST_GSID;
    end
    else if (wr_go && wr_data[7:4] == MAKER_NIBBLE)
    begin
      if (addr == tcbsr_pkg::ADDR_SID2 && (cls_bc || cls_sa == sid2))
        sid2 <= wr_data[3:0];
      if (addr == tcbsr_pkg::ADDR_SID3 && (cls_bc || cls_sa == sid3))
        sid3 <= wr_data[3:0];
    end
    // any unique identifier may write it
    if (resetn_in && !startup && !shutdown_in && wr_go && !cls_bc && !cls_grp
      && addr == tcbsr_pkg::ADDR_GSID)
      gsid <= wr_data[3:0];
  end

  // ****************************************
  // Output channels and read-timing register
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in || startup)
    begin
      rd_edge <= tcbsr_pkg::RST_EDGE;
      for (int i = 0; i < 2; i++)
      begin
        shadow[i] <= tcbsr_pkg::RST_OUT;
        chan_out[i] <= '0;
      end
    end
    // soft reset; in the frame's last cycle; memory values
    else if (swr_go)
    begin
      rd_edge <= otp_valid_in ? otp_in.rd_edge : tcbsr_pkg::RST_EDGE;
      for (int i = 0; i < 2; i++)
      begin
        shadow[i] <= otp_valid_in ? otp_in.out_val[i] : tcbsr_pkg::RST_OUT;
        {chan_out[i].glide, chan_out[i].target} <= otp_valid_in ? otp_in.out_val[i]
          : tcbsr_pkg::RST_OUT;
        chan_out[i].glide_start <= 1'b0;
        chan_out[i].turbo_start <= 1'b0;
      end
    end
    else
    begin
      if (wr_go && !cls_grp && addr == tcbsr_pkg::ADDR_RD_EDGE)
        rd_edge <= wr_data[tcbsr_pkg::EDGE_BIT];
      for (int i = 0; i < 2; i++)
      begin
        // step delay is the plain timer value
        chan_out[i].step_delay <= step_timer_in[i];
        chan_out[i].glide_start <= 1'b0;
        chan_out[i].turbo_start <= 1'b0;
        if (chan_wr[i])
          shadow[i] <= wr_data;
        if (chan_wr[i] && trig_mask_in[i])
        begin
          {chan_out[i].glide, chan_out[i].target} <= wr_data;
          chan_out[i].glide_start <= wr_data[7] && (step_timer_in[i] != 5'h00);
          chan_out[i].turbo_start <= !wr_data[7] && (step_timer_in[i] != 5'h00);
        end
        else if (trig_fire_in[i] && !trig_mask_in[i])
        begin
          {chan_out[i].glide, chan_out[i].target} <= shadow[i];
          chan_out[i].glide_start <= shadow[i][7] && (step_timer_in[i] != 5'h00);
          chan_out[i].turbo_start <= !shadow[i][7] && (step_timer_in[i] != 5'h00);
        end
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in || startup)
      flags_out <= tcbsr_pkg::RST_FLAGS;
    // hardware set wins over read and soft-reset clears
    else
      flags_out <= ((swr_go || stat_clr) ? tcbsr_pkg::RST_FLAGS : flags_out) | flag_set;
  end

  // ****************************************
  // Writes for registers kept elsewhere
  // ****************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in)
      ext_wr_out <= '0;
    else
    begin
      ext_wr_out.valid <= wr_go && ext_hit;
      ext_wr_out.group <= cls_grp;
      ext_wr_out.bcast <= cls_bc;
      ext_wr_out.addr <= addr[4:0];
      // group writes keep power mode and trigger bits only
      ext_wr_out.data <= cls_grp ? (wr_data & tcbsr_pkg::GROUP_WR_MASK) : wr_data;
    end
  end

endmodule

/* File: verification/tcbsr_regs_props.sv */
module tcbsr_regs_props (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic sdata_oe_out,
  input wire logic [1:0] power_state_in,
  input wire logic [1:0] trig_mask_in,
  input wire logic [1:0] trig_fire_in,
  input wire tcbsr_pkg::tcbsr_chan_t [1:0] chan_out,
  input wire tcbsr_pkg::tcbsr_ext_wr_t ext_wr_out,
  input wire logic [6:0] flags_out
);
  default clocking dc @(posedge ref_clk_in);
  endclocking
  default disable iff (!resetn_in);
  // Length of one answer; two bytes would run far past the bound
  logic [7:0] oe_run;
  always_ff @(posedge ref_clk_in)
  begin
    if (!resetn_in || !sdata_oe_out)
      oe_run <= 8'h00;
    else
      oe_run <= oe_run + 8'h01;
  end
  chk_glide_flag: assert property (
    chan_out[0].glide_start |-> chan_out[0].glide && !chan_out[0].turbo_start)
    else $error("glide start without glide bit");
  chk_glide_pulse: assert property (
    chan_out[0].glide_start |=> !chan_out[0].glide_start)
    else $error("glide start longer than one cycle");
  chk_turbo_flag: assert property (
    chan_out[1].turbo_start |-> !chan_out[1].glide)
    else $error("turbo start with glide bit set");
  chk_turbo_pulse: assert property (
    $rose(chan_out[0].turbo_start) |=> $fell(chan_out[0].turbo_start))
    else $error("turbo start longer than one cycle");
  chk_group_only: assert property (
    ext_wr_out.valid && ext_wr_out.group |-> ext_wr_out.addr == 5'h1C
      && (ext_wr_out.data & ~tcbsr_pkg::GROUP_WR_MASK) == 8'h00)
    else $error("group write outside allowed bits");
  chk_startup_flags: assert property (
    power_state_in == tcbsr_pkg::PM_STARTUP |=> flags_out == 7'h00)
    else $error("flags kept through startup mode");
  chk_held_target: assert property (
    !trig_mask_in[0] && !$past(trig_mask_in[0]) && !trig_fire_in[0]
      && !$past(trig_fire_in[0]) |=> $stable(chan_out[0].target))
    else $error("active value moved without trigger");
  chk_read_bound: assert property (
    oe_run <= 8'h58)
    else $error("data line driven longer than one byte");
  chk_read_whole: assert property (
    $fell(sdata_oe_out) |-> oe_run >= 8'h48)
    else $error("answer byte cut short");
endmodule

bind tcbsr_regs tcbsr_regs_props u_props (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
  .sdata_oe_out(sdata_oe_out), .power_state_in(power_state_in), .trig_mask_in(trig_mask_in),
  .trig_fire_in(trig_fire_in), .chan_out(chan_out), .ext_wr_out(ext_wr_out),
  .flags_out(flags_out));

/* File: verification/tcbsr_bus_master.sv */
module tcbsr_bus_master (
  output logic sclk_out,
  output logic line_out,
  input wire logic dut_data_in,
  input wire logic dut_oe_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic d = 1'b0;
  logic en = 1'b1;
  logic fall_mode = 1'b0;
  // Released line shows the inverse of the parked level, never a held copy
  assign line_out = dut_oe_in ? dut_data_in : (en ? d : ~d);
  initial sclk_out = 1'b0;
  task automatic bit_out(input logic b);
    sclk_out = 1'b1;
    #100 d = b;
    #300 sclk_out = 1'b0;
    #400;
  endtask
  task automatic ssc();
    #800 d = 1'b1;
    #800 d = 1'b0;
    #800;
  endtask
  task automatic frame(input logic [11:0] v, input int n, input logic bad);
    logic p;
    p = ~bad;
    for (int i = n - 1; i >= 0; i--)
    begin
      p ^= v[i];
      bit_out(v[i]);
    end
    bit_out(p);
  endtask
  task automatic wr(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] v,
    input logic cbad, input logic dbad);
    ssc();
    frame({sa, 3'b010, a}, 12, cbad);
    frame({4'h0, v}, 8, dbad);
    bit_out(1'b0);
  endtask
  task automatic rd(input logic [3:0] sa, input logic [7:0] c, input logic [7:0] a,
    input logic abad, output logic [8:0] q);
    ssc();
    frame({sa, c}, 12, 1'b0);
    if (c[7:5] != 3'b011)
      frame({4'h0, a}, 8, abad);
    q = '0;
    for (int k = 1; k < 12; k++)
    begin
      sclk_out = 1'b1;
      #100 d = 1'b0;
      // sample before the fall in falling mode, before the rise otherwise
      #250 if (fall_mode && k > 1 && k < 11) q[10 - k] = line_out;
      #50 sclk_out = 1'b0;
      en = (k == 11);
      #350 if (!fall_mode && k > 1 && k < 11) q[10 - k] = line_out;
      #50;
    end
  endtask
endmodule

/* File: verification/tcbsr_regs_test.sv */
module tcbsr_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Maker nibble is arbitrary
  localparam logic [3:0] MK = 4'hA;
  logic ref_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sclk, line, dout, doe;
  logic [3:0] sid1 = 4'h1;
  logic [1:0] pst = 2'h0;
  logic shut = 1'b0;
  logic [1:0] mask = 2'h3;
  logic [1:0] fire = 2'h0;
  logic [1:0][4:0] tmr = {5'h03, 5'h04};
  logic otpv = 1'b0;
  tcbsr_pkg::tcbsr_otp_t otp = '0;
  tcbsr_pkg::tcbsr_chan_t [1:0] chan;
  tcbsr_pkg::tcbsr_ext_wr_t ext;
  logic [6:0] flags;
  logic [8:0] q;
  int errors = 0;
  int n_compared = 0;
  always #50 ref_clk_in = ~ref_clk_in;
  tcbsr_bus_master m (.sclk_out(sclk), .line_out(line), .dut_data_in(dout), .dut_oe_in(doe));
  tcbsr_regs #(.MAKER_NIBBLE(MK)) dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .sclk_in(sclk), .sdata_in(line), .sdata_out(dout), .sdata_oe_out(doe),
    .first_sid_in(sid1), .power_state_in(pst), .shutdown_in(shut), .trig_mask_in(mask),
    .trig_fire_in(fire), .step_timer_in(tmr), .otp_valid_in(otpv), .otp_in(otp),
    .chan_out(chan), .ext_wr_out(ext), .flags_out(flags));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register read with the answer byte and its odd parity
  task automatic rc(input logic [4:0] a, input logic [7:0] v);
    m.rd(sid1, {3'b011, a}, 8'h00, 1'b0, q);
    chk(q, {v, ~^v});
  endtask
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #5000000;
    errors++;
    stop_test();
  end
  initial
  begin
    repeat (16) @(negedge ref_clk_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    rc(5'h07, 8'h00);
    rc(5'h18, {MK, 4'h7});
    $display("Test reset done");
    m.wr(sid1, 5'h07, 8'h85, 1'b0, 1'b0);
    m.wr(sid1, 5'h08, 8'h12, 1'b0, 1'b0);
    chk({chan[0].glide, chan[0].target, chan[1].glide}, {1'b1, 7'h05, 1'b0});
    chk({4'h0, chan[0].step_delay}, {4'h0, tmr[0]});
    rc(5'h08, 8'h12);
    mask = 2'h2;
    m.wr(sid1, 5'h07, 8'h33, 1'b0, 1'b0);
    rc(5'h07, 8'h85);
    @(negedge ref_clk_in) fire = 2'h1;
    @(negedge ref_clk_in) fire = 2'h0;
    rc(5'h07, 8'h33);
    mask = 2'h3;
    $display("Test outputs done");
    m.wr(sid1, 5'h09, 8'h01, 1'b0, 1'b0);
    m.fall_mode = 1'b1;
    rc(5'h09, 8'h01);
    m.wr(sid1, 5'h09, 8'h00, 1'b0, 1'b0);
    m.fall_mode = 1'b0;
    m.wr(4'h0, 5'h18, {MK, 4'h3}, 1'b0, 1'b0);
    m.wr(4'h3, 5'h18, {MK, 4'h5}, 1'b0, 1'b0);
    m.wr(4'h5, 5'h18, 8'h56, 1'b0, 1'b0);
    rc(5'h18, {MK, 4'h5});
    m.wr(sid1, 5'h1B, 8'h04, 1'b0, 1'b0);
    m.wr(4'h4, 5'h07, 8'h77, 1'b0, 1'b0);
    m.wr(4'h4, 5'h1C, 8'hFF, 1'b0, 1'b0);
    rc(5'h07, 8'h33);
    $display("Test identifiers done");
    m.ssc();
    m.frame({sid1, 8'h01}, 12, 1'b0);
    m.frame({4'h0, 8'h07}, 8, 1'b0);
    m.frame({4'h0, 8'h99}, 8, 1'b1);
    m.frame({4'h0, 8'h5A}, 8, 1'b0);
    m.bit_out(1'b0);
    rc(5'h07, 8'h33);
    rc(5'h08, 8'h5A);
    m.rd(sid1, 8'h21, 8'h07, 1'b0, q);
    chk(q, {8'h33, ~^8'h33});
    m.rd(4'h0, 8'h67, 8'h00, 1'b0, q);
    m.wr(sid1, 5'h0A, 8'h11, 1'b0, 1'b0);
    m.rd(sid1, 8'h6B, 8'h00, 1'b0, q);
    chk(q, 9'h1FF);
    m.wr(sid1, 5'h08, 8'h44, 1'b0, 1'b1);
    m.rd(sid1, 8'h20, 8'h07, 1'b1, q);
    m.ssc();
    m.frame(12'h00F, 5, 1'b0);
    m.wr(sid1, 5'h08, 8'h12, 1'b0, 1'b0);
    m.wr(sid1, 5'h08, 8'h66, 1'b1, 1'b0);
    chk({2'b00, flags}, 9'h07F);
    rc(5'h1A, 8'h7F);
    chk({2'b00, flags}, 9'h000);
    rc(5'h08, 8'h12);
    $display("Test errors done");
    otpv = 1'b1;
    otp.out_val[0] = 8'h2C;
    m.wr(sid1, 5'h1A, 8'h80, 1'b0, 1'b0);
    chk({2'b00, chan[0].target}, 9'h02C);
    rc(5'h07, 8'h2C);
    rc(5'h18, {MK, 4'h5});
    rc(5'h1B, 8'h04);
    shut = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    shut = 1'b0;
    rc(5'h18, {MK, 4'h7});
    rc(5'h1B, 8'h00);
    m.wr(sid1, 5'h0A, 8'h11, 1'b0, 1'b0);
    pst = tcbsr_pkg::PM_STARTUP;
    repeat (2) @(negedge ref_clk_in);
    pst = 2'h0;
    chk({2'b00, flags}, 9'h000);
    $display("Test resets done");
    stop_test();
  end
endmodule
